//--- include/serial_config_pkg.sv
// Constants, types and layouts for the serial configuration port block.
// Assumes a converter core on ref_clk and a host driving the pins.
//
// Function
// - Loading starts only with select low and start bit high on first active edge.
// - Bipolar and range-double bits pick 0-5, 0-10, +-5 or +-10 V range.
// - Power-down bit high powers the converter down; low runs it normally.
// - Port stays writable in power-down; host writes power-down low to restore.
// - Fast and low-power bits pick normal, low-power, fast or normal mode.
// - Coding bit low gives twos complement results, high gives straight binary.
// - Result port is a slave and is read only after conversion completes.
// - Read-after-conversion slave mode supports daisy-chaining converters.
// - Data goes in MSB first from start bit; settings apply on ninth edge.
// - The two lowest configuration bits are reserved and stay unchanged.
// - Reset clears all configuration bits: 0-5 V, normal mode, twos complement.
// - Port works only in serial interface and software configuration modes; the code enables it only with serialMode high and softwareConfig low.
package serial_config_pkg;

   // ****************************************
   // Register layout
   // ****************************************
   localparam int          CFG_WIDTH        = 9;
   localparam int          BIT_START        = 8;
   localparam int          BIT_BIPOLAR      = 7;
   localparam int          BIT_RANGE_DOUBLE = 6;
   localparam int          BIT_POWERDOWN    = 5;
   localparam int          BIT_LOW_POWER    = 4;
   localparam int          BIT_FAST         = 3;
   localparam int          BIT_CODING       = 2;
   localparam int          RSV_HI           = 1;
   localparam int          RSV_LO           = 0;
   localparam logic [8:0]  CFG_RESET        = 9'h000;
   localparam logic [3:0]  CFG_EDGES        = 4'h9;
   localparam int          RESULT_WIDTH     = 14;
   localparam logic [3:0]  RESULT_BITS      = 4'he;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {RANGE_0_5, RANGE_0_10, RANGE_PM5, RANGE_PM10} range_e;
   typedef enum logic [1:0] {MODE_NORMAL, MODE_LOW_POWER, MODE_FAST} mode_e;

   typedef struct packed {
      range_e     inputRange;
      mode_e      convMode;
      logic       powerDown;
      logic       straightBinary;
      logic [1:0] reservedBits;
   } converter_cfg_s;

   typedef struct packed {
      logic readClk;
      logic readSelectN;
      logic daisyIn;
      logic sclkInvert;
   } read_pins_s;

endpackage : serial_config_pkg

//--- rtl/result_readout.sv
// Serial slave that shifts out a conversion result after busy falls.
// Assumes pins arrive asynchronously and busy and result come from ref_clk logic.
module result_readout
   import serial_config_pkg::*;
(
   // Clock and reset
   input  wire logic                            ref_clk,
   input  wire logic                            sys_rst,
   // Converter core
   input  wire logic                            busy,
   input  wire logic [RESULT_WIDTH-1:0]         resultCode,
   input  wire logic                            straightBinary,
   // Host pins
   input  wire serial_config_pkg::read_pins_s   readPins,
   output logic                                 resultDataOut
);

   read_pins_s                pinMeta, pinSync, pinPrev;
   logic                      busyPrev;
   logic                      daisyLatch, next_daisyLatch;
   logic [RESULT_WIDTH-1:0]   shiftReg, next_shiftReg;
   logic                      shiftEdge, latchEdge, clkNow, clkPrev, selected;

   // Two-stage synchroniser, then a history stage for edge detection
   always_ff @(posedge ref_clk) begin
      pinMeta  <= readPins;
      pinSync  <= pinMeta;
      pinPrev  <= pinSync;
      busyPrev <= sys_rst ? 1'b0 : busy;
   end

   // Edge picks follow the clock inversion strap
   assign clkNow    = pinSync.readClk ^ pinSync.sclkInvert;
   assign clkPrev   = pinPrev.readClk ^ pinPrev.sclkInvert;
   assign selected  = !pinSync.readSelectN && !busy;
   assign shiftEdge = selected && clkNow && !clkPrev;
   assign latchEdge = selected && !clkNow && clkPrev;

   // Load on end of conversion, shift out, chain upstream data in
   always_comb begin
      next_shiftReg   = shiftReg;
      next_daisyLatch = daisyLatch;
      if (busyPrev && !busy) begin
         next_shiftReg = straightBinary ? resultCode
                       : {~resultCode[RESULT_WIDTH-1], resultCode[RESULT_WIDTH-2:0]};
      end else if (shiftEdge) begin
         next_shiftReg = {shiftReg[RESULT_WIDTH-2:0], daisyLatch};
      end
      if (latchEdge) begin
         next_daisyLatch = pinSync.daisyIn;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         shiftReg      <= '0;
         daisyLatch    <= 1'b0;
         resultDataOut <= 1'b0;
      end else begin
         shiftReg      <= next_shiftReg;
         daisyLatch    <= next_daisyLatch;
         resultDataOut <= next_shiftReg[RESULT_WIDTH-1];
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   chk_coding_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (busyPrev && !busy) |=> shiftReg[RESULT_WIDTH-1] ==
         ($past(resultCode[RESULT_WIDTH-1]) ^ !$past(straightBinary)))
      else $error("result coding wrong at load");
   chk_busy_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (busy && busyPrev) |=> $stable(shiftReg))
      else $error("result moved during conversion");
   chk_daisy_shift: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (shiftEdge && !(busyPrev && !busy)) |=> shiftReg[0] == $past(daisyLatch))
      else $error("chained bit not shifted in");

endmodule : result_readout

//--- rtl/serial_config_register_port.sv
// Write-only serial configuration port with its configuration register,
// plus the read-after-conversion result slave.
// Assumes the converter core consumes converterCfg and reports busy on ref_clk.
module serial_config_register_port
   import serial_config_pkg::*;
(
   // System clock and reset
   input  wire logic                                 ref_clk,
   input  wire logic                                 sys_rst,
   // Configuration port pins
   input  wire logic                                 cfg_port_clock,
   input  wire logic                                 cfg_port_select_n,
   input  wire logic                                 cfg_port_data_in,
   input  wire logic                                 serial_clock_invert,
   // Interface mode straps
   input  wire logic                                 serialMode,
   input  wire logic                                 softwareConfig,
   // Converter core
   input  wire logic                                 busy,
   input  wire logic [serial_config_pkg::RESULT_WIDTH-1:0] resultCode,
   output serial_config_pkg::converter_cfg_s         converterCfg,
   output logic [serial_config_pkg::CFG_WIDTH-1:0]   converter_configuration,
   output logic                                      configUpdated,
   // Result read pins
   input  wire serial_config_pkg::read_pins_s        readPins,
   output logic                                      resultDataOut
);

   // ****************************************
   // Decode helpers
   // ****************************************

   // Range from bipolar and range-double bits
   function automatic range_e decodeRange(input logic bipolar, input logic rangeDouble);
      unique case ({bipolar, rangeDouble})
         2'b00: decodeRange = RANGE_0_5;
         2'b01: decodeRange = RANGE_0_10;
         2'b10: decodeRange = RANGE_PM5;
         2'b11: decodeRange = RANGE_PM10;
      endcase
   endfunction : decodeRange

   // Mode from fast and low-power bits; both set falls back to normal
   function automatic mode_e decodeMode(input logic fast, input logic lowPower);
      unique case ({fast, lowPower})
         2'b01:   decodeMode = MODE_LOW_POWER;
         2'b10:   decodeMode = MODE_FAST;
         default: decodeMode = MODE_NORMAL;
      endcase
   endfunction : decodeMode

   // ****************************************
   // Link domain: configuration shifter
   // ****************************************
   logic       linkClk;
   logic [3:0] edgeCount, next_edgeCount;
   logic       loading,   next_loading;
   logic       frameDone, next_frameDone;
   logic [7:0] shiftWord, next_shiftWord;

   // Active edge is rising, or falling when the strap inverts it; strap is static
   assign linkClk = cfg_port_clock ^ serial_clock_invert;

   // Edge one takes the start bit, edges two to nine take the eight setting bits
   always_comb begin
      next_edgeCount = edgeCount;
      next_loading   = loading;
      next_frameDone = frameDone;
      next_shiftWord = shiftWord;
      if (edgeCount != CFG_EDGES) begin
         next_edgeCount = edgeCount + 4'h1;
         if (edgeCount == 4'h0) begin
            next_loading = cfg_port_data_in;
         end else if (loading) begin
            next_shiftWord = {shiftWord[6:0], cfg_port_data_in};
            if (edgeCount == CFG_EDGES - 4'h1) begin
               next_frameDone = 1'b1;
            end
         end
      end
   end

   // Select high holds the shifter idle, so stray clocks do nothing
   always_ff @(posedge linkClk or posedge cfg_port_select_n) begin
      if (cfg_port_select_n) begin
         edgeCount <= 4'h0;
         loading   <= 1'b0;
         frameDone <= 1'b0;
      end else begin
         edgeCount <= next_edgeCount;
         loading   <= next_loading;
         frameDone <= next_frameDone;
      end
   end

   // Data word needs no reset; it is only read once frameDone has been seen
   always_ff @(posedge linkClk) begin
      shiftWord <= next_shiftWord;
   end

   // ****************************************
   // System domain: crossing and register
   // ****************************************
   logic                 doneMeta, doneSync, doneSeen;
   logic [1:0]           modeMeta, modeSync;
   logic                 applyWord, portEnabled;
   logic [CFG_WIDTH-1:0] cfgReg, next_cfgReg;
   converter_cfg_s       next_converterCfg;

   // Level crossing for frame completion and the mode straps
   always_ff @(posedge ref_clk) begin
      doneMeta <= frameDone;
      doneSync <= doneMeta;
      modeMeta <= {serialMode, softwareConfig};
      modeSync <= modeMeta;
      doneSeen <= sys_rst ? 1'b0 : doneSync;
   end

   // Word is stable while frameDone is high and until the second edge of the next started frame
   assign applyWord   = doneSync && !doneSeen;
   assign portEnabled = modeSync == 2'b10;

   // Next register value and its decoded view
   always_comb begin
      next_cfgReg = cfgReg;
      if (applyWord && portEnabled) begin
         next_cfgReg = {cfgReg[BIT_START], shiftWord[7:2], cfgReg[RSV_HI:RSV_LO]};
      end
      next_converterCfg.inputRange     = decodeRange(next_cfgReg[BIT_BIPOLAR],
                                                     next_cfgReg[BIT_RANGE_DOUBLE]);
      next_converterCfg.convMode       = decodeMode(next_cfgReg[BIT_FAST],
                                                    next_cfgReg[BIT_LOW_POWER]);
      next_converterCfg.powerDown      = next_cfgReg[BIT_POWERDOWN];
      next_converterCfg.straightBinary = next_cfgReg[BIT_CODING];
      next_converterCfg.reservedBits   = next_cfgReg[RSV_HI:RSV_LO];
   end

   // Register and outputs, cleared by reset
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cfgReg        <= CFG_RESET;
         converterCfg  <= '{RANGE_0_5, MODE_NORMAL, 1'b0, 1'b0, 2'b00};
         configUpdated <= 1'b0;
      end else begin
         cfgReg        <= next_cfgReg;
         converterCfg  <= next_converterCfg;
         configUpdated <= applyWord && portEnabled;
      end
   end

   assign converter_configuration = cfgReg;

   // ****************************************
   // Result slave
   // ****************************************
   result_readout u_readout (
      .ref_clk        (ref_clk),
      .sys_rst        (sys_rst),
      .busy           (busy),
      .resultCode     (resultCode),
      .straightBinary (converterCfg.straightBinary),
      .readPins       (readPins),
      .resultDataOut  (resultDataOut)
   );

   // ****************************************
   // Checks
   // ****************************************
   sequence startTaken;
      edgeCount == 4'h0 && cfg_port_data_in;
   endsequence

   sequence sevenBits;
      loading [*7];
   endsequence

   // The link clock stops after edge nine, so completion is seen as the value that edge loads
   property frameLoads;
      @(posedge linkClk) disable iff (cfg_port_select_n)
         startTaken ##1 sevenBits |=> next_frameDone;
   endproperty

   chk_start_gate: assert property (@(posedge linkClk) disable iff (cfg_port_select_n)
      (edgeCount == 4'h0 && !cfg_port_data_in) |=> !loading [*8])
      else $error("load began without start bit");
   chk_ninth_edge: assert property (frameLoads)
      else $error("settings not ready on ninth edge");
   chk_done_count: assert property (@(posedge linkClk) disable iff (cfg_port_select_n)
      $rose(frameDone) |-> edgeCount == CFG_EDGES)
      else $error("frame done at wrong edge");
   chk_reset_clear: assert property (@(posedge ref_clk)
      sys_rst |=> cfgReg == CFG_RESET && converterCfg.convMode == MODE_NORMAL)
      else $error("reset did not clear config");
   chk_mode_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !portEnabled |=> $stable(cfgReg))
      else $error("config changed outside software mode");
   chk_reserved_keep: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ##1 cfgReg[RSV_HI:RSV_LO] == $past(cfgReg[RSV_HI:RSV_LO]))
      else $error("reserved bits changed");
   chk_pd_writable: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (converterCfg.powerDown && applyWord && portEnabled) |=> configUpdated &&
         converterCfg.powerDown == $past(shiftWord[BIT_POWERDOWN]))
      else $error("power-down blocked a write");
   chk_apply_word: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (applyWord && portEnabled) |=> configUpdated &&
         cfgReg[BIT_BIPOLAR:BIT_CODING] == $past(shiftWord[7:2]) &&
         converterCfg.powerDown == cfgReg[BIT_POWERDOWN])
      else $error("written word not applied");
   chk_range_map: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (applyWord && portEnabled && shiftWord[7:6] == 2'b01) |=> converterCfg.inputRange == RANGE_0_10)
      else $error("range decode wrong");
   chk_mode_map: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (applyWord && portEnabled && shiftWord[BIT_LOW_POWER:BIT_FAST] == 2'b11) |=>
         converterCfg.convMode == MODE_NORMAL)
      else $error("both mode bits must mean normal");

endmodule : serial_config_register_port

//--- sim/cfg_host_model.sv
// Host model: drives configuration frames and reads results as serial master.
// Assumes straps are static and the read clock polarity strap is low.
module cfg_host_model
   import serial_config_pkg::*;
(
   // Configuration port
   output logic                         cfgClk,
   output logic                         cfgSelN,
   output logic                         cfgData,
   // Result read port
   output serial_config_pkg::read_pins_s readPins,
   input  wire logic                    resultDataOut,
   input  wire logic                    busy
);
   timeunit 1ns;
   timeprecision 100ps;

   // ****************************************
   // Idle levels: link clock stands still between frames
   // ****************************************
   initial begin
      cfgClk   = 1'b0;
      cfgSelN  = 1'b0;
      cfgData  = 1'b0;
      readPins = '{readClk: 1'b0, readSelectN: 1'b1, daisyIn: 1'b1, sclkInvert: 1'b0};
      #2 cfgSelN = 1'b1;               // Rising select clears the shifter after time zero
   end

   // Frame of edges bits, start bit first, 6 ns link clock
   task automatic send_frame(input logic [8:0] word, input int edges, input logic selLevel);
      int i;
      cfgSelN = selLevel;
      #5;
      for (i = 0; i < edges; i++) begin
         cfgData = word[8 - (i % 9)];
         #3 cfgClk = 1'b1;
         #3 cfgClk = 1'b0;
      end
      cfgData = ~cfgData;              // Released data shows no stale value
      #200;
      cfgSelN = 1'b1;
      #10;
   endtask : send_frame

   // Read after conversion, clock polarity 0 and phase 1, 12.5 MHz
   // Fourteen result bits, one gap bit, then the first chained bit
   task automatic read_result(output logic [15:0] bits);
      int i;
      wait (busy === 1'b0);
      #40 readPins.readSelectN = 1'b0;
      #40 bits[15] = resultDataOut;
      for (i = 14; i >= 0; i--) begin
         readPins.readClk = 1'b1;
         #40 bits[i] = resultDataOut;
         readPins.readClk = 1'b0;
         #40;
      end
      readPins.readSelectN = 1'b1;
   endtask : read_result
endmodule : cfg_host_model

//--- sim/serial_config_register_port_tb.sv
// Testbench for the serial configuration port and result slave.
// Assumes the host model drives the pins; bench plays the converter core.
module serial_config_register_port_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import serial_config_pkg::*;

   logic ref_clk = 1'b0, sys_rst = 1'b1, serialMode = 1'b1, softwareConfig = 1'b0, busy = 1'b0;
   logic cfgClk, cfgSelN, cfgData, configUpdated, resultDataOut;
   logic [RESULT_WIDTH-1:0] resultCode = 14'h1a5c;
   logic [CFG_WIDTH-1:0]    cfgWord;
   converter_cfg_s          converterCfg;
   read_pins_s              readPins;
   logic [15:0]             bits;
   int fails = 0, num_checks = 0, updates = 0, cycles = 0, n;

   // ****************************************
   // Clock, design and host
   // ****************************************
   always #4 ref_clk = ~ref_clk;

   serial_config_register_port uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .cfg_port_clock(cfgClk),
      .cfg_port_select_n(cfgSelN), .cfg_port_data_in(cfgData), .serial_clock_invert(1'b0),
      .serialMode(serialMode), .softwareConfig(softwareConfig), .busy(busy), .resultCode(resultCode),
      .converterCfg(converterCfg), .converter_configuration(cfgWord), .configUpdated(configUpdated),
      .readPins(readPins), .resultDataOut(resultDataOut));

   cfg_host_model uHost (.cfgClk(cfgClk), .cfgSelN(cfgSelN), .cfgData(cfgData), .readPins(readPins),
      .resultDataOut(resultDataOut), .busy(busy));

   // Count applied words and cut a hang short
   always @(posedge ref_clk) begin
      if (configUpdated === 1'b1) updates++;
      cycles++;
      if (cycles == 20000) begin
         fails++;
         stop_test();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] expVal, input string what);
      num_checks++;
      if (seen !== expVal) begin
         fails++;
         $display("Error at %0t: %s seen %h expected %h", $time, what, seen, expVal);
      end
   endtask : check

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test

   // Valid frame; stored word drops the start bit and the reserved bits
   task automatic write_cfg(input logic [7:0] payload);
      n = updates;
      uHost.send_frame({1'b1, payload}, 9, 1'b0);
      check(updates - n, 1, "update pulse");
      check(cfgWord, {1'b0, payload[7:2], 2'b00}, "raw word");
   endtask : write_cfg

   // Busy falls, then host reads 14 bits, one gap bit and one chained bit
   task automatic read_and_check(input logic [13:0] expCode);
      @(negedge ref_clk) busy = 1'b1;
      repeat (20) @(negedge ref_clk);
      busy = 1'b0;
      uHost.read_result(bits);
      check({bits[15:2], bits[0]}, {expCode, 1'b1}, "result bits");
   endtask : read_and_check

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (12) @(negedge ref_clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      check(cfgWord, CFG_RESET, "reset word");
      check(converterCfg, 8'h00, "reset settings");
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         write_cfg({i[1:0], 6'b000000});
         check(converterCfg.inputRange, i, "range");
      end
      $display("range test done");
      for (int i = 0; i < 4; i++) begin
         write_cfg({3'b000, i[1:0], 3'b011});
         check(converterCfg.convMode, (i == 1) ? 2 : (i == 2) ? 1 : 0, "mode");
         check(converterCfg.reservedBits, 2'b00, "reserved");
      end
      $display("mode test done");
      write_cfg(8'h20);
      check(converterCfg.powerDown, 1'b1, "power down");
      write_cfg(8'h04);
      check(converterCfg.powerDown, 1'b0, "power up");
      check(converterCfg.straightBinary, 1'b1, "coding");
      $display("power test done");
      n = updates;
      uHost.send_frame(9'h104, 10, 1'b0);
      check(updates - n, 1, "long frame");
      check(cfgWord, 9'h004, "long frame word");
      n = updates;
      uHost.send_frame(9'h0ff, 9, 1'b0);
      uHost.send_frame(9'h1ff, 8, 1'b0);
      uHost.send_frame(9'h1ff, 9, 1'b1);
      @(negedge ref_clk) serialMode = 1'b0;
      repeat (4) @(negedge ref_clk);
      uHost.send_frame(9'h1ff, 9, 1'b0);
      @(negedge ref_clk) serialMode = 1'b1;
      repeat (4) @(negedge ref_clk);
      check(updates - n, 0, "refused frames");
      check(cfgWord, 9'h004, "kept word");
      $display("refusal test done");
      read_and_check(14'h1a5c);
      @(negedge ref_clk) sys_rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      check(cfgWord, CFG_RESET, "mid-run reset word");
      check(converterCfg, 8'h00, "mid-run reset settings");
      write_cfg(8'h00);
      read_and_check(14'h1a5c ^ 14'h2000);
      $display("read test done");
      stop_test();
   end
endmodule : serial_config_register_port_tb
